/* File: design/amg_guard.sv */
`timescale 1ns/10ps

module amg_guard #(
	parameter int unsigned                  NUM_REGIONS = 8,
	parameter logic [amg_pkg::ADDR_W-1:0] PRIV_BASE   = 32'h0000_0000,
	parameter logic [amg_pkg::ADDR_W-1:0] PRIV_LIMIT  = 32'h0000_ffff,
	parameter logic [amg_pkg::ADDR_W-1:0] CFG_BASE    = 32'hf000_0000
) (
	// clock, reset, enable
	input  wire logic                     i_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_ce,
	// core request
	input  wire logic                     i_req_valid,
	input  wire amg_pkg::amg_req_s        i_req,
	// memory side
	output logic                          o_mem_valid,
	output amg_pkg::amg_mem_req_s         o_mem_req,
	input  wire logic [amg_pkg::DATA_W-1:0] i_mem_rdata,
	// core response
	output logic                          o_rsp_valid,
	output amg_pkg::amg_rsp_s             o_rsp,
	output logic                          o_violation
);

	// elaboration checks: refuse settings the decode cannot serve
	if (NUM_REGIONS < 1 || NUM_REGIONS > amg_pkg::MAX_REGIONS) begin
		$error("amg_guard: NUM_REGIONS must be 1 to 8");
	end
	if (CFG_BASE[7:0] != 8'h00) begin
		$error("amg_guard: CFG_BASE must be 256-byte aligned");
	end
	if (PRIV_BASE > PRIV_LIMIT) begin
		$error("amg_guard: PRIV_BASE above PRIV_LIMIT");
	end

	localparam int unsigned RIDX_W = 3;

	// region configuration state
	logic [amg_pkg::ADDR_W-1:0] base_reg  [NUM_REGIONS];
	logic [amg_pkg::ADDR_W-1:0] base_next [NUM_REGIONS];
	logic [amg_pkg::ADDR_W-1:0] limit_reg [NUM_REGIONS];
	logic [amg_pkg::ADDR_W-1:0] limit_next[NUM_REGIONS];
	logic [amg_pkg::ATTR_W-1:0] attr_reg  [NUM_REGIONS];
	logic [amg_pkg::ATTR_W-1:0] attr_next [NUM_REGIONS];
	logic [7:0]                 own_reg;
	logic [7:0]                 own_next;
	logic [amg_pkg::ADDR_W-1:0] fault_addr_reg;
	logic [amg_pkg::ADDR_W-1:0] fault_addr_next;
	logic [6:0]                 fault_info_reg;
	logic [6:0]                 fault_info_next;

	// pipeline state
	logic                       mem_valid_reg;
	logic                       mem_valid_next;
	amg_pkg::amg_mem_req_s      mem_req_reg;
	amg_pkg::amg_mem_req_s      mem_req_next;
	logic                       viol_reg;
	logic                       viol_next;
	logic                       s1_valid_reg;
	logic                       s1_valid_next;
	logic                       s1_local_reg;
	logic                       s1_local_next;
	amg_pkg::amg_rsp_s          s1_rsp_reg;
	amg_pkg::amg_rsp_s          s1_rsp_next;
	logic                       s2_valid_reg;
	logic                       s2_valid_next;
	logic                       s2_local_reg;
	logic                       s2_local_next;
	amg_pkg::amg_rsp_s          s2_rsp_reg;
	amg_pkg::amg_rsp_s          s2_rsp_next;
	logic                       rsp_valid_reg;
	logic                       rsp_valid_next;
	amg_pkg::amg_rsp_s          rsp_reg;
	amg_pkg::amg_rsp_s          rsp_next;

	// decision terms
	logic                       eff_priv;
	logic                       in_priv;
	logic                       cfg_hit;
	logic [amg_pkg::CFG_IDX_W-1:0] cfg_idx;
	logic                       hit_any;
	logic [RIDX_W-1:0]          hit_idx;
	logic [3:0]                 hit_rights;
	logic                       allowed;
	logic                       cfg_write;
	logic [amg_pkg::DATA_W-1:0] cfg_rdata;

	// level and area decode
	always_comb begin
		eff_priv = i_req.priv | i_req.irq;
		in_priv  = (i_req.addr >= PRIV_BASE) && (i_req.addr <= PRIV_LIMIT);
		cfg_hit  = (i_req.addr[amg_pkg::ADDR_W-1:8] == CFG_BASE[amg_pkg::ADDR_W-1:8]);
		cfg_idx  = i_req.addr[7:2];
	end

	// region match: later (higher-numbered) matches overwrite earlier ones
	always_comb begin
		hit_any    = 1'b0;
		hit_idx    = '0;
		hit_rights = 4'h0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (attr_reg[i][amg_pkg::ATTR_EN_BIT] &&
			    (i_req.addr >= base_reg[i]) && (i_req.addr <= limit_reg[i])) begin
				hit_any    = 1'b1;
				hit_idx    = RIDX_W'(i);
				hit_rights = attr_reg[i][3:0];
			end
		end
	end

	// permit or deny from level, area and operation
	// the window test comes first, so no level can execute from register space
	always_comb begin
		if (cfg_hit) begin
			allowed = eff_priv && (i_req.op != amg_pkg::AMG_OP_EXEC);
		end else if (eff_priv) begin
			allowed = 1'b1;
		end else if (in_priv) begin
			allowed = 1'b0;
		end else if (hit_any && own_reg[hit_idx]) begin
			allowed = |(hit_rights & i_req.op);
		end else begin
			allowed = 1'b0;
		end
	end

	// configuration read data
	always_comb begin
		cfg_rdata = '0;
		if (cfg_idx == amg_pkg::CFG_OWN_MASK_IDX) begin
			cfg_rdata = {24'h00_0000, own_reg};
		end else if (cfg_idx == amg_pkg::CFG_FAULT_ADDR_IDX) begin
			cfg_rdata = fault_addr_reg;
		end else if (cfg_idx == amg_pkg::CFG_FAULT_INFO_IDX) begin
			cfg_rdata = {25'h000_0000, fault_info_reg};
		end else begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				if (cfg_idx[5:2] == 4'(i)) begin
					unique case (cfg_idx[1:0])
						amg_pkg::CFG_REG_BASE_FLD[1:0]:  cfg_rdata = base_reg[i];
						amg_pkg::CFG_REG_LIMIT_FLD[1:0]: cfg_rdata = limit_reg[i];
						amg_pkg::CFG_REG_ATTR_FLD[1:0]:  cfg_rdata = {27'h000_0000, attr_reg[i]};
						default:                         cfg_rdata = '0;
					endcase
				end
			end
		end
	end

	// configuration next values
	always_comb begin
		cfg_write       = i_req_valid && cfg_hit && allowed &&
		                  (i_req.op != amg_pkg::AMG_OP_READ);
		own_next        = own_reg;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			base_next[i]  = base_reg[i];
			limit_next[i] = limit_reg[i];
			attr_next[i]  = attr_reg[i];
		end
		if (cfg_write) begin
			// delete puts a field back to its manufacturing default
			if (cfg_idx == amg_pkg::CFG_OWN_MASK_IDX) begin
				own_next = (i_req.op == amg_pkg::AMG_OP_DELETE) ? amg_pkg::DEF_OWN_MASK : i_req.wdata[7:0];
			end
			for (int i = 0; i < NUM_REGIONS; i++) begin
				if (cfg_idx[5:2] == 4'(i)) begin
					unique case (cfg_idx[1:0])
						amg_pkg::CFG_REG_BASE_FLD[1:0]: begin
							base_next[i] = (i_req.op == amg_pkg::AMG_OP_DELETE) ?
							               amg_pkg::DEF_REGION_BASE : i_req.wdata;
						end
						amg_pkg::CFG_REG_LIMIT_FLD[1:0]: begin
							limit_next[i] = (i_req.op == amg_pkg::AMG_OP_DELETE) ?
							                amg_pkg::DEF_REGION_LIMIT : i_req.wdata;
						end
						amg_pkg::CFG_REG_ATTR_FLD[1:0]: begin
							attr_next[i] = (i_req.op == amg_pkg::AMG_OP_DELETE) ?
							               amg_pkg::DEF_REGION_ATTR : i_req.wdata[amg_pkg::ATTR_W-1:0];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				base_reg[i]  <= amg_pkg::DEF_REGION_BASE;
				limit_reg[i] <= amg_pkg::DEF_REGION_LIMIT;
				attr_reg[i]  <= amg_pkg::DEF_REGION_ATTR;
			end
			own_reg        <= amg_pkg::DEF_OWN_MASK;
		end else if (i_ce) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				base_reg[i]  <= base_next[i];
				limit_reg[i] <= limit_next[i];
				attr_reg[i]  <= attr_next[i];
			end
			own_reg        <= own_next;
		end
	end

	// fault record: every denial overwrites it, the last one wins
	always_comb begin
		fault_addr_next = fault_addr_reg;
		fault_info_next = fault_info_reg;
		if (i_req_valid && !allowed) begin
			fault_addr_next = i_req.addr;
			fault_info_next = {i_req.jump, i_req.irq, i_req.priv, i_req.op};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fault_addr_reg <= '0;
			fault_info_reg <= '0;
		end else if (i_ce) begin
			fault_addr_reg <= fault_addr_next;
			fault_info_reg <= fault_info_next;
		end
	end

	// pipeline: request, memory access, memory data, response
	// memory cannot stall, so each response lands three enabled cycles after its request
	always_comb begin
		mem_valid_next    = i_req_valid && allowed && !cfg_hit;
		mem_req_next      = mem_req_reg;
		if (i_req_valid) begin
			mem_req_next.addr  = i_req.addr;
			mem_req_next.wdata = i_req.wdata;
			mem_req_next.op    = i_req.op;
		end
		viol_next         = i_req_valid && !allowed;
		s1_valid_next     = i_req_valid;
		s1_local_next     = !(allowed && !cfg_hit);
		s1_rsp_next.err   = !allowed;
		s1_rsp_next.rdata = (allowed && cfg_hit && i_req.op == amg_pkg::AMG_OP_READ) ? cfg_rdata : '0;
		s2_valid_next     = s1_valid_reg;
		s2_local_next     = s1_local_reg;
		s2_rsp_next       = s1_rsp_reg;
		rsp_valid_next    = s2_valid_reg;
		rsp_next.err      = s2_rsp_reg.err;
		rsp_next.rdata    = s2_local_reg ? s2_rsp_reg.rdata : i_mem_rdata;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mem_valid_reg <= 1'b0;
			mem_req_reg   <= '0;
			viol_reg      <= 1'b0;
			s1_valid_reg  <= 1'b0;
			s1_local_reg  <= 1'b0;
			s1_rsp_reg    <= '0;
			s2_valid_reg  <= 1'b0;
			s2_local_reg  <= 1'b0;
			s2_rsp_reg    <= '0;
			rsp_valid_reg <= 1'b0;
			rsp_reg       <= '0;
		end else if (i_ce) begin
			mem_valid_reg <= mem_valid_next;
			mem_req_reg   <= mem_req_next;
			viol_reg      <= viol_next;
			s1_valid_reg  <= s1_valid_next;
			s1_local_reg  <= s1_local_next;
			s1_rsp_reg    <= s1_rsp_next;
			s2_valid_reg  <= s2_valid_next;
			s2_local_reg  <= s2_local_next;
			s2_rsp_reg    <= s2_rsp_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg       <= rsp_next;
		end
	end

	assign o_mem_valid = mem_valid_reg;
	assign o_mem_req   = mem_req_reg;
	assign o_violation = viol_reg;
	assign o_rsp_valid = rsp_valid_reg;
	assign o_rsp       = rsp_reg;

endmodule

/* File: design/amg_pkg.sv */
package amg_pkg;

	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MAX_REGIONS = 8;

	// operation codes, one-hot so a rights mask can be tested with a plain and
	typedef enum logic [3:0] {
		AMG_OP_READ   = 4'h1,
		AMG_OP_WRITE  = 4'h2,
		AMG_OP_DELETE = 4'h4,
		AMG_OP_EXEC   = 4'h8
	} amg_op_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		amg_op_e           op;
		logic              priv;
		logic              irq;
		logic              jump;
	} amg_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		amg_op_e           op;
	} amg_mem_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              err;
	} amg_rsp_s;

	// configuration window layout, word index = byte offset / 4
	localparam logic [5:0] CFG_REG_BASE_FLD  = 6'h00;
	localparam logic [5:0] CFG_REG_LIMIT_FLD = 6'h01;
	localparam logic [5:0] CFG_REG_ATTR_FLD  = 6'h02;
	localparam logic [5:0] CFG_OWN_MASK_IDX  = 6'h20;
	localparam logic [5:0] CFG_FAULT_ADDR_IDX = 6'h21;
	localparam logic [5:0] CFG_FAULT_INFO_IDX = 6'h22;
	localparam int unsigned CFG_IDX_W = 6;

	// attribute word: bit 4 enable, bits 3:0 rights (read, write, delete, exec)
	localparam int unsigned ATTR_EN_BIT = 4;
	localparam int unsigned ATTR_W = 5;

	// manufacturing defaults: regions closed, all of them owned
	localparam logic [ADDR_W-1:0] DEF_REGION_BASE  = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] DEF_REGION_LIMIT = 32'h0000_0000;
	localparam logic [ATTR_W-1:0] DEF_REGION_ATTR  = 5'h00;
	localparam logic [7:0]        DEF_OWN_MASK     = 8'hff;

endpackage

/* File: verification/amg_guard_checker.sv */
`timescale 1ns/10ps
module amg_guard_checker #(
	parameter logic [31:0] PRIV_BASE  = 32'h0000_0000,
	parameter logic [31:0] PRIV_LIMIT = 32'h0000_ffff,
	parameter logic [31:0] CFG_BASE   = 32'hf000_0000
) (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire logic                   i_ce,
	input wire logic                   i_req_valid,
	input wire amg_pkg::amg_req_s      i_req,
	input wire logic                   o_mem_valid,
	input wire amg_pkg::amg_mem_req_s  o_mem_req,
	input wire logic [amg_pkg::DATA_W-1:0] i_mem_rdata,
	input wire logic                   o_rsp_valid,
	input wire amg_pkg::amg_rsp_s      o_rsp,
	input wire logic                   o_violation
);
	wire logic usr  = !i_req.priv && !i_req.irq;
	wire logic cfg  = i_req.addr[31:8] == CFG_BASE[31:8];
	wire logic take = i_ce && i_req_valid;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	rsp_latency_a: assert property (take ##1 i_ce [*2] |=> o_rsp_valid)
		else $error("response not three cycles after request");
	deny_silent_a: assert property (o_violation |-> !o_mem_valid)
		else $error("memory access issued on a denial");
	user_priv_a: assert property (take && usr && !cfg && i_req.addr >= PRIV_BASE &&
		i_req.addr <= PRIV_LIMIT |=> o_violation)
		else $error("user access into privileged area not denied");
	priv_pass_a: assert property (take && !usr && !cfg |=> o_mem_valid &&
		o_mem_req.addr == $past(i_req.addr) && o_mem_req.op == $past(i_req.op))
		else $error("privileged access not passed to memory");
	cfg_exec_a: assert property (take && cfg && i_req.op == amg_pkg::AMG_OP_EXEC |=> o_violation)
		else $error("execute on configuration not denied");
	cfg_nomem_a: assert property (take && cfg |=> !o_mem_valid)
		else $error("configuration access leaked to memory");
	deny_rsp_a: assert property (o_violation && i_ce ##1 i_ce |=>
		o_rsp_valid && o_rsp.err && o_rsp.rdata == 32'h0)
		else $error("denied response wrong");
	read_data_a: assert property (o_mem_valid && i_ce ##1 i_ce |=>
		o_rsp_valid && !o_rsp.err && o_rsp.rdata == $past(i_mem_rdata))
		else $error("memory data not returned");
endmodule

bind amg_guard amg_guard_checker #(.PRIV_BASE(PRIV_BASE), .PRIV_LIMIT(PRIV_LIMIT), .CFG_BASE(CFG_BASE)) u_amg_guard_checker (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req_valid(i_req_valid), .i_req(i_req),
	.o_mem_valid(o_mem_valid), .o_mem_req(o_mem_req), .i_mem_rdata(i_mem_rdata),
	.o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_violation(o_violation)
);

/* File: verification/amg_guard_tb.sv */
`timescale 1ns/10ps
module amg_guard_tb;
	typedef struct packed {logic p; logic i; logic j; logic [3:0] op; logic [31:0] a; logic err;} amg_row_s;
	localparam logic [31:0] CB = 32'hf000_0000;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0;
	amg_pkg::amg_req_s     req = '0;
	amg_pkg::amg_mem_req_s mem_req;
	amg_pkg::amg_rsp_s     rsp, got;
	logic [31:0] mem_rdata;
	logic mem_valid, rsp_valid, viol, mv, vi, rv;
	int error_cnt = 0, n_checks = 0;
	amg_row_s r;
	amg_row_s rows[13] = '{
		'{0,0,0,4'h1,32'h0001_0000,0}, '{0,0,0,4'h2,32'h0001_0004,0}, '{0,0,0,4'h4,32'h0001_0008,1},
		'{0,0,0,4'h2,32'h0001_8000,1}, '{0,0,0,4'h1,32'h0001_8004,0},
		'{0,0,0,4'h1,32'h0002_0000,1}, '{0,0,0,4'h1,32'h0000_0100,1}, '{0,0,0,4'h8,32'h0003_0000,1},
		'{1,0,0,4'h2,32'h0002_0000,0}, '{0,1,0,4'h8,32'h0000_0100,0},
		'{1,0,0,4'h8,32'hf000_0080,1}, '{0,0,0,4'h1,32'hf000_0080,1}, '{0,0,1,4'h8,32'h0001_0000,1}};
	// region 0 read/write, region 1 read only above it, region 2 not owned
	logic [39:0] init[10] = '{{8'h00,32'h0001_0000}, {8'h04,32'h0001_ffff}, {8'h08,32'h13}, {8'h10,32'h0001_8000},
		{8'h14,32'h0001_ffff}, {8'h18,32'h11}, {8'h20,32'h0002_0000}, {8'h24,32'h0002_ffff}, {8'h28,32'h1f}, {8'h80,32'h03}};

	amg_guard u_amg_guard (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_req_valid(req_valid), .i_req(req),
		.o_mem_valid(mem_valid), .o_mem_req(mem_req), .i_mem_rdata(mem_rdata),
		.o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_violation(viol));
	amg_mem_model u_amg_mem_model (.i_clk(clk), .i_ce(ce), .i_valid(mem_valid), .i_req(mem_req), .o_rdata(mem_rdata));

	initial forever #5 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic access(input logic p, i, j, input amg_pkg::amg_op_e op, input logic [31:0] a, d);
		@(posedge clk);
		req <= '{addr:a, wdata:d, op:op, priv:p, irq:i, jump:j};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		#1 mv = mem_valid;
		vi = viol;
		repeat (2) @(posedge clk);
		#1 rv = rsp_valid;
		got = rsp;
	endtask

	task automatic creg(input logic u, input amg_pkg::amg_op_e op, input logic [7:0] off, input logic [31:0] d);
		access(!u, 1'b0, 1'b0, op, CB + 32'(off), d);
		check(32'({mv, rv, got.err}), {29'h0, 1'b0, 1'b1, u});
		check(got.rdata, (u || op != amg_pkg::AMG_OP_READ) ? 32'h0 : d);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#50000;
		error_cnt++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 check(32'({mem_valid, rsp_valid, viol}), 32'h0);
		creg(0, amg_pkg::AMG_OP_READ, 8'h08, 32'h0);
		creg(0, amg_pkg::AMG_OP_READ, 8'h80, 32'hff);
		foreach (init[k]) creg(0, amg_pkg::AMG_OP_WRITE, init[k][39:32], init[k][31:0]);
		foreach (rows[k]) begin
			r = rows[k];
			access(r.p, r.i, r.j, amg_pkg::amg_op_e'(r.op), r.a, ~r.a);
			check(32'({mv, vi, rv, got.err}), 32'({!r.err && r.a < CB, r.err, 1'b1, r.err}));
			check(got.rdata, r.err ? 32'h0 : r.a ^ 32'h5a5a_5a5a);
		end
		creg(0, amg_pkg::AMG_OP_READ, 8'h84, 32'h0001_0000);
		creg(0, amg_pkg::AMG_OP_READ, 8'h88, 32'h48);
		creg(1, amg_pkg::AMG_OP_WRITE, 8'h18, 32'h1f);
		creg(0, amg_pkg::AMG_OP_READ, 8'h18, 32'h11);
		creg(0, amg_pkg::AMG_OP_DELETE, 8'h18, 32'h0);
		creg(0, amg_pkg::AMG_OP_READ, 8'h18, 32'h0);
		// a taken request waits, outputs frozen, while the enable is low
		@(posedge clk);
		req <= '{addr:32'h0002_0010, wdata:32'h1234_5678,
			op:amg_pkg::AMG_OP_WRITE, priv:1'b1, irq:1'b0, jump:1'b0};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		#1 check(32'({mem_valid, viol, rsp_valid}), 32'h4);
		check(mem_req.addr, 32'h0002_0010);
		check(mem_req.wdata, 32'h1234_5678);
		@(posedge clk);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		#1 check(32'({mem_valid, rsp_valid, rsp.err}), 32'h2);
		check(rsp.rdata, 32'h0002_0010 ^ 32'h5a5a_5a5a);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		creg(0, amg_pkg::AMG_OP_READ, 8'h80, 32'hff);
		creg(0, amg_pkg::AMG_OP_READ, 8'h28, 32'h0);
		close_out();
	end
endmodule

/* File: verification/amg_mem_model.sv */
`timescale 1ns/10ps
module amg_mem_model (
	input  wire logic                  i_clk,
	input  wire logic                  i_ce,
	input  wire logic                  i_valid,
	input  wire amg_pkg::amg_mem_req_s i_req,
	output logic [amg_pkg::DATA_W-1:0] o_rdata
);
	initial begin
		o_rdata = 32'h0;
	end
	// data valid for one enabled cycle after the issue, inverted on idle cycles
	always @(posedge i_clk) begin
		if (i_ce) begin
			o_rdata <= i_valid ? i_req.addr ^ 32'h5a5a_5a5a : ~o_rdata;
		end
	end
endmodule
